/* File: bench/rcse_exec_tb.sv */
// rcse_exec_tb.sv: self-checking bench for the rotate/halt execution block
`timescale 1ns/1ps
`default_nettype none
`include "rcse_map.svh"
`define CHK(nm, e, g) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            failures++; \
            $display("[ERR] %s expected %h seen %h", nm, e, g); \
        end \
    end
module rcse_exec_tb;
    import rcse_pkg::*;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    rcse_word_t instr_i = 12'h000;
    logic instr_vld_i = 1'b0;
    rcse_byte_t file_rdata_i = 8'h00;
    logic wake_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    rcse_wbadr_t wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    rcse_wbdat_t wb_dat_i = 32'h0000_0000;
    logic wb_ack_o;
    rcse_wbdat_t wb_dat_o;
    logic file_we_o;
    rcse_faddr_t file_addr_o;
    rcse_byte_t file_wdata_o;
    rcse_byte_t w_o;
    logic carry_o;
    logic timeout_status_bit_o;
    logic powerdown_status_bit_o;
    logic wdt_clr_o;
    logic prescaler_clr_o;
    logic sleep_o;
    logic osc_stop_o;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #2.5 mclk_i = ~mclk_i;

    rcse_exec dut
    (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .instr_i(instr_i), .instr_vld_i(instr_vld_i), .file_rdata_i(file_rdata_i),
        .wake_i(wake_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .file_we_o(file_we_o),
        .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o), .w_o(w_o),
        .carry_o(carry_o), .timeout_status_bit_o(timeout_status_bit_o),
        .powerdown_status_bit_o(powerdown_status_bit_o), .wdt_clr_o(wdt_clr_o),
        .prescaler_clr_o(prescaler_clr_o), .sleep_o(sleep_o), .osc_stop_o(osc_stop_o)
    );

    // ----------------------------------------
    // closing report
    // ----------------------------------------
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // whole run needs under a hundred cycles; the 2000-cycle ceiling leaves ample slack
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            close_out();
        end
    end

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic wb_xfer(input logic we, input rcse_wbadr_t adr, input logic [3:0] sel,
                           input rcse_wbdat_t dat, output rcse_wbdat_t got);
        int n;
        n = 0;
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        // pre-edge values are seen here, so ack is sampled as the edge saw it
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        // a missing ack counts as a mismatch, not a silent fall-through
        `CHK("wb ack", 1'b1, wb_ack_o)
        got = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input rcse_wbadr_t adr, input rcse_wbdat_t exp);
        rcse_wbdat_t got;
        wb_xfer(1'b0, adr, 4'h1, 32'h0000_0000, got);
        `CHK(nm, exp, got)
    endtask

    task automatic wr(input rcse_wbadr_t adr, input logic [3:0] sel, input rcse_wbdat_t dat);
        rcse_wbdat_t got;
        wb_xfer(1'b1, adr, sel, dat, got);
    endtask

    // one instruction, checked 1 ns after the edge that takes it
    task automatic ex(input rcse_word_t op, input rcse_byte_t fd);
        @(posedge mclk_i);
        instr_i <= op;
        instr_vld_i <= 1'b1;
        file_rdata_i <= fd;
        @(posedge mclk_i);
        instr_vld_i <= 1'b0;
        file_rdata_i <= ~fd;
        #1;
    endtask

    task automatic tick;
        @(posedge mclk_i);
        #1;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        #1;
        `CHK("w reset", 8'h00, w_o)
        `CHK("to reset", 1'b1, timeout_status_bit_o)
        `CHK("pd reset", 1'b1, powerdown_status_bit_o)
        `CHK("sleep reset", 1'b0, sleep_o)
        rd_chk("ctrl reset", `RCSE_ADR_CTRL, 32'h0000_0001);
        rd_chk("stat reset", `RCSE_ADR_STAT, 32'h0000_0006);
        rd_chk("wreg reset", `RCSE_ADR_WREG, 32'h0000_0000);
        ex(12'h345, 8'he6);
        `CHK("rl w", 8'hcc, w_o)
        `CHK("rl c", 1'b1, carry_o)
        `CHK("rl no file write", 1'b0, file_we_o)
        ex(12'h307, 8'he6);
        `CHK("rr w", 8'hf3, w_o)
        `CHK("rr c", 1'b0, carry_o)
        ex(12'h37f, 8'h80);
        `CHK("rl file we", 1'b1, file_we_o)
        `CHK("rl file addr", 5'h1f, file_addr_o)
        `CHK("rl file data", 8'h00, file_wdata_o)
        `CHK("rl d1 w kept", 8'hf3, w_o)
        `CHK("rl d1 c", 1'b1, carry_o)
        tick();
        `CHK("file we pulse", 1'b0, file_we_o)
        ex(12'h320, 8'h01);
        `CHK("rr file addr", 5'h00, file_addr_o)
        `CHK("rr file data", 8'h80, file_wdata_o)
        `CHK("rr d1 c", 1'b1, carry_o)
        ex(12'h1c5, 8'h3c);
        `CHK("other op w", 8'hf3, w_o)
        `CHK("other op c", 1'b1, carry_o)
        rd_chk("stat run", `RCSE_ADR_STAT, 32'h0000_0007);
        rd_chk("unmapped", 8'h0c, 32'h0000_0000);
        wr(`RCSE_ADR_WREG, 4'h1, 32'h0000_005a);
        rd_chk("wreg", `RCSE_ADR_WREG, 32'h0000_005a);
        wr(`RCSE_ADR_WREG, 4'h0, 32'h0000_00a5);
        wr(`RCSE_ADR_STAT, 4'h1, 32'h0000_0000);
        rd_chk("wreg sel0", `RCSE_ADR_WREG, 32'h0000_005a);
        rd_chk("stat ro", `RCSE_ADR_STAT, 32'h0000_0007);
        // halt with the prescaler on the watchdog
        ex(12'h003, 8'h00);
        `CHK("halt to", 1'b1, timeout_status_bit_o)
        `CHK("halt pd", 1'b0, powerdown_status_bit_o)
        `CHK("halt wdt clr", 1'b1, wdt_clr_o)
        `CHK("halt psc clr", 1'b1, prescaler_clr_o)
        `CHK("halt sleep", 1'b1, sleep_o)
        `CHK("halt osc stop", 1'b1, osc_stop_o)
        tick();
        `CHK("wdt clr pulse", 1'b0, wdt_clr_o)
        `CHK("psc clr pulse", 1'b0, prescaler_clr_o)
        `CHK("sleep held", 1'b1, sleep_o)
        rd_chk("stat halt", `RCSE_ADR_STAT, 32'h0000_000b);
        ex(12'h345, 8'h0f);
        `CHK("halted no exec", 8'h5a, w_o)
        @(posedge mclk_i);
        wake_i <= 1'b1;
        @(posedge mclk_i);
        wake_i <= 1'b0;
        #1;
        `CHK("wake sleep", 1'b0, sleep_o)
        `CHK("wake osc", 1'b0, osc_stop_o)
        // prescaler moved away: only the watchdog is cleared
        wr(`RCSE_ADR_CTRL, 4'h1, 32'h0000_0000);
        rd_chk("ctrl psa", `RCSE_ADR_CTRL, 32'h0000_0000);
        ex(12'h003, 8'h00);
        `CHK("halt2 wdt clr", 1'b1, wdt_clr_o)
        `CHK("halt2 psc kept", 1'b0, prescaler_clr_o)
        `CHK("halt2 sleep", 1'b1, sleep_o)
        wr(`RCSE_ADR_CTRL, 4'h1, 32'h0000_0002);
        tick();
        `CHK("sw wake", 1'b0, sleep_o)
        ex(12'h345, 8'h01);
        `CHK("run again w", 8'h03, w_o)
        // enable low: a rotate must leave every flop as it was
        @(posedge mclk_i);
        ce_i <= 1'b0;
        ex(12'h345, 8'h81);
        `CHK("frozen w", 8'h03, w_o)
        `CHK("frozen c", 1'b0, carry_o)
        @(posedge mclk_i);
        ce_i <= 1'b1;
        close_out();
    end
endmodule
`default_nettype wire

/* File: hw/rcse_exec.sv */
// rcse_exec.sv: rotate-through-carry and halt execution with wishbone regs
//
// Operation
// RL1: left rotate shifts file byte up; carry into bit 0, bit 7 to carry.
// RL2: right rotate shifts file byte down; carry into bit 7, bit 0 to carry.
// RL3: destination bit clear sends result to working register, file untouched.
// RL4: destination bit set writes result back to addressed file register.
// RL5: halt sets the time-out status bit to one.
// RL6: halt clears the power-down status bit to zero.
// RL7: halt loads watchdog with zero; clears prescaler only if assigned to it.
// RL8: halt puts the core into low-power halt and stops the oscillator.
// RL9: each opcode is one word, one cycle; file addresses 0 to 31.
`timescale 1ns/1ps
`default_nettype none
`include "rcse_map.svh"
module rcse_exec
(
    // clock, reset, enable
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // instruction from the core
    input wire rcse_pkg::rcse_word_t instr_i,
    input wire logic instr_vld_i,
    input wire rcse_pkg::rcse_byte_t file_rdata_i,
    // wake from the core's wake-up logic
    input wire logic wake_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire rcse_pkg::rcse_wbadr_t wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire rcse_pkg::rcse_wbdat_t wb_dat_i,
    output logic wb_ack_o,
    output rcse_pkg::rcse_wbdat_t wb_dat_o,
    // register file write port
    output logic file_we_o,
    output rcse_pkg::rcse_faddr_t file_addr_o,
    output rcse_pkg::rcse_byte_t file_wdata_o,
    // working register and status
    output rcse_pkg::rcse_byte_t w_o,
    output logic carry_o,
    output logic timeout_status_bit_o,
    output logic powerdown_status_bit_o,
    // watchdog and power control
    output logic wdt_clr_o,
    output logic prescaler_clr_o,
    output logic sleep_o,
    output logic osc_stop_o
);
    import rcse_pkg::*;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic rcse_op_t op_decode(input rcse_word_t ins);
        rcse_op_t op;
        op = RCSE_OP_NONE;
        if (ins[`RCSE_OPC_HI:`RCSE_OPC_LO] == `RCSE_OPC_RLC)
        begin
            op = RCSE_OP_RLC;
        end
        else if (ins[`RCSE_OPC_HI:`RCSE_OPC_LO] == `RCSE_OPC_RRC)
        begin
            op = RCSE_OP_RRC;
        end
        else if (ins == `RCSE_OP_HALT)
        begin
            op = RCSE_OP_HALT;
        end
        return op;
    endfunction

    rcse_state_t state_r;
    rcse_state_t state_nxt;
    rcse_op_t op;
    logic exec;
    logic is_rot;
    logic dst_f;
    logic psa_r;
    logic sw_wake;
    logic wb_req;
    logic wb_wr;
    logic w_bus_wr;

    rcse_rot_if rot_if ();

    rcse_rot u_rot
    (
        .rot(rot_if.unit)
    );

    // one word per opcode; address field covers 0..31
    assign op = op_decode(instr_i); // [RL9]
    assign exec = ce_i && instr_vld_i && (state_r == RCSE_RUN);
    assign is_rot = (op == RCSE_OP_RLC) || (op == RCSE_OP_RRC);
    assign dst_f = instr_i[`RCSE_DST_BIT];

    assign rot_if.src = file_rdata_i;
    assign rot_if.cin = carry_o;
    assign rot_if.left = (op == RCSE_OP_RLC); // [RL1] [RL2]

    // ----------------------------------------
    // run / halt state
    // ----------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            RCSE_RUN:
            begin
                if (exec && op == RCSE_OP_HALT)
                begin
                    state_nxt = RCSE_HALT; // [RL8]
                end
            end
            RCSE_HALT:
            begin
                if (wake_i || sw_wake)
                begin
                    state_nxt = RCSE_RUN;
                end
            end
            default:
            begin
                state_nxt = RCSE_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= RCSE_RUN;
        end
        else if (ce_i)
        begin
            state_r <= state_nxt;
        end
    end

    // outputs track the state from a flop of their own
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sleep_o <= 1'b0;
            osc_stop_o <= 1'b0;
        end
        else if (ce_i)
        begin
            sleep_o <= (state_nxt == RCSE_HALT); // [RL8]
            osc_stop_o <= (state_nxt == RCSE_HALT); // [RL8]
        end
    end

    // ----------------------------------------
    // working register
    // ----------------------------------------
    // instruction result beats a same-cycle bus write
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            w_o <= `RCSE_RST_W;
        end
        else if (ce_i)
        begin
            if (exec && is_rot && !dst_f)
            begin
                w_o <= rot_if.res; // [RL3]
            end
            else if (w_bus_wr)
            begin
                w_o <= wb_dat_i[`RCSE_MSB:`RCSE_LSB];
            end
        end
    end

    // ----------------------------------------
    // file write-back
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            file_we_o <= 1'b0;
            file_addr_o <= '0;
            file_wdata_o <= '0;
        end
        else if (ce_i)
        begin
            file_we_o <= exec && is_rot && dst_f; // [RL4] [RL3]
            if (exec && is_rot && dst_f)
            begin
                file_addr_o <= instr_i[`RCSE_FA_HI:`RCSE_FA_LO]; // [RL4]
                file_wdata_o <= rot_if.res; // [RL4]
            end
        end
    end

    // ----------------------------------------
    // carry
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            carry_o <= `RCSE_RST_C;
        end
        else if (ce_i && exec && is_rot)
        begin
            carry_o <= rot_if.cout; // [RL1] [RL2]
        end
    end

    // ----------------------------------------
    // time-out and power-down status
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            timeout_status_bit_o <= `RCSE_RST_TO;
            powerdown_status_bit_o <= `RCSE_RST_PD;
        end
        else if (ce_i && exec && op == RCSE_OP_HALT)
        begin
            timeout_status_bit_o <= 1'b1; // [RL5]
            powerdown_status_bit_o <= 1'b0; // [RL6]
        end
    end

    // ----------------------------------------
    // watchdog clear pulses
    // ----------------------------------------
    // pulse means the watchdog loads RCSE_WDT_ZERO
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wdt_clr_o <= 1'b0;
            prescaler_clr_o <= 1'b0;
        end
        else if (ce_i)
        begin
            wdt_clr_o <= exec && op == RCSE_OP_HALT; // [RL7]
            prescaler_clr_o <= exec && op == RCSE_OP_HALT && psa_r; // [RL7]
        end
    end

    // ----------------------------------------
    // wishbone slave
    // ----------------------------------------
    // one wait state; ack drops in the cycle after it rose
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = ce_i && wb_req && wb_we_i;
    assign w_bus_wr = wb_wr && wb_adr_i == `RCSE_ADR_WREG && wb_sel_i[`RCSE_LANE0];
    assign sw_wake = wb_wr && wb_adr_i == `RCSE_ADR_CTRL && wb_sel_i[`RCSE_LANE0]
                     && wb_dat_i[`RCSE_CTRL_WAKE];

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            psa_r <= `RCSE_RST_PSA;
        end
        else if (wb_wr && wb_adr_i == `RCSE_ADR_CTRL && wb_sel_i[`RCSE_LANE0])
        begin
            psa_r <= wb_dat_i[`RCSE_CTRL_PSA];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wb_ack_o <= 1'b0;
        end
        else if (ce_i)
        begin
            wb_ack_o <= wb_req;
        end
    end

    // unmapped offsets read zero and ignore writes
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wb_dat_o <= `RCSE_ZERO32;
        end
        else if (ce_i)
        begin
            wb_dat_o <= `RCSE_ZERO32;
            if (wb_req && !wb_we_i)
            begin
                unique case (wb_adr_i)
                    `RCSE_ADR_CTRL:
                    begin
                        wb_dat_o[`RCSE_CTRL_PSA] <= psa_r;
                    end
                    `RCSE_ADR_STAT:
                    begin
                        wb_dat_o[`RCSE_STAT_C] <= carry_o;
                        wb_dat_o[`RCSE_STAT_TO] <= timeout_status_bit_o;
                        wb_dat_o[`RCSE_STAT_PD] <= powerdown_status_bit_o;
                        wb_dat_o[`RCSE_STAT_SLP] <= sleep_o;
                    end
                    `RCSE_ADR_WREG:
                    begin
                        wb_dat_o[`RCSE_MSB:`RCSE_LSB] <= w_o;
                    end
                    default:
                    begin
                        wb_dat_o <= `RCSE_ZERO32;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_RLC_W: assert property ( // [RL1]
        exec && op == RCSE_OP_RLC && !dst_f
        |=> w_o == {$past(file_rdata_i[6:0]), $past(carry_o)}
            && carry_o == $past(file_rdata_i[7]))
        else $error("left rotate result or carry wrong");

    AST_RRC_W: assert property ( // [RL2]
        exec && op == RCSE_OP_RRC && !dst_f
        |=> w_o == {$past(carry_o), $past(file_rdata_i[7:1])}
            && carry_o == $past(file_rdata_i[0]))
        else $error("right rotate result or carry wrong");

    AST_KEEP_FILE: assert property ( // [RL3]
        exec && is_rot && !dst_f |=> !file_we_o)
        else $error("file written when result goes to working reg");

    AST_WRITE_FILE: assert property ( // [RL4]
        exec && is_rot && dst_f
        |=> file_we_o && file_addr_o == $past(instr_i[`RCSE_FA_HI:`RCSE_FA_LO])
            && (w_o == $past(w_o) || $past(w_bus_wr)))
        else $error("file write-back missing or working reg changed");

    AST_TO_SET: assert property ( // [RL5]
        exec && op == RCSE_OP_HALT |=> timeout_status_bit_o)
        else $error("time-out bit not set by halt");

    AST_PD_CLR: assert property ( // [RL6]
        exec && op == RCSE_OP_HALT |=> !powerdown_status_bit_o)
        else $error("power-down bit not cleared by halt");

    AST_WDT_CLR: assert property ( // [RL7]
        exec && op == RCSE_OP_HALT
        |=> wdt_clr_o && prescaler_clr_o == $past(psa_r))
        else $error("watchdog or prescaler clear wrong");

    AST_HALT_ENTER: assert property ( // [RL8]
        exec && op == RCSE_OP_HALT
        |=> sleep_o && osc_stop_o && state_r == RCSE_HALT)
        else $error("halt not entered after halt opcode");

    AST_HALT_HOLD: assert property ( // [RL8]
        ce_i && sleep_o && !wake_i && !sw_wake
        |=> sleep_o && ($stable(w_o) || $past(w_bus_wr)))
        else $error("left halt without wake");

    AST_ONE_CYCLE: assert property ( // [RL9]
        ce_i && file_we_o && !(exec && is_rot && dst_f) |=> !file_we_o)
        else $error("write-back longer than one cycle");

    AST_ACK_PULSE: assert property (
        ce_i && wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");
endmodule
`default_nettype wire

/* File: hw/rcse_map.svh */
// rcse_map.svh: opcodes, field positions, offsets and reset values
`ifndef RCSE_MAP_SVH
`define RCSE_MAP_SVH

// ----------------------------------------
// opcode fields
// ----------------------------------------
`define RCSE_OPC_HI 11
`define RCSE_OPC_LO 6
`define RCSE_OPC_RLC 6'h0d
`define RCSE_OPC_RRC 6'h0c
`define RCSE_OP_HALT 12'h003
`define RCSE_DST_BIT 5
`define RCSE_FA_HI 4
`define RCSE_FA_LO 0
`define RCSE_MSB 7
`define RCSE_LSB 0

// ----------------------------------------
// register offsets and bits
// ----------------------------------------
`define RCSE_ADR_CTRL 8'h00
`define RCSE_ADR_STAT 8'h04
`define RCSE_ADR_WREG 8'h08
`define RCSE_CTRL_PSA 0
`define RCSE_CTRL_WAKE 1
`define RCSE_STAT_C 0
`define RCSE_STAT_TO 1
`define RCSE_STAT_PD 2
`define RCSE_STAT_SLP 3
`define RCSE_LANE0 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RCSE_RST_W 8'h00
`define RCSE_RST_C 1'b0
`define RCSE_RST_TO 1'b1
`define RCSE_RST_PD 1'b1
`define RCSE_RST_PSA 1'b1
`define RCSE_WDT_ZERO 8'h00
`define RCSE_ZERO32 32'h0000_0000

`endif

/* File: hw/rcse_pkg.sv */
// rcse_pkg.sv: types shared by the rotate/halt execution block
package rcse_pkg;
    typedef logic [11:0] rcse_word_t;
    typedef logic [7:0] rcse_byte_t;
    typedef logic [4:0] rcse_faddr_t;
    typedef logic [31:0] rcse_wbdat_t;
    typedef logic [7:0] rcse_wbadr_t;
    typedef enum logic [1:0]
    {
        RCSE_RUN = 2'b01,
        RCSE_HALT = 2'b10
    } rcse_state_t;
    typedef enum logic [1:0]
    {
        RCSE_OP_NONE = 2'b00,
        RCSE_OP_RLC = 2'b01,
        RCSE_OP_RRC = 2'b10,
        RCSE_OP_HALT = 2'b11
    } rcse_op_t;
endpackage

/* File: hw/rcse_rot.sv */
// rcse_rot.sv: 9-bit rotate of a byte through the carry
`timescale 1ns/1ps
`default_nettype none
`include "rcse_map.svh"
module rcse_rot
(
    // operands and result
    rcse_rot_if.unit rot
);
    import rcse_pkg::*;

    always_comb
    begin
        if (rot.left)
        begin
            rot.res = {rot.src[`RCSE_MSB-1:`RCSE_LSB], rot.cin};
            rot.cout = rot.src[`RCSE_MSB];
        end
        else
        begin
            rot.res = {rot.cin, rot.src[`RCSE_MSB:`RCSE_LSB+1]};
            rot.cout = rot.src[`RCSE_LSB];
        end
    end
endmodule
`default_nettype wire

/* File: hw/rcse_rot_if.sv */
// rcse_rot_if.sv: link between the core logic and the rotate unit
`timescale 1ns/1ps
`default_nettype none
interface rcse_rot_if;
    logic [7:0] src;
    logic cin;
    logic left;
    logic [7:0] res;
    logic cout;
    modport core
    (
        output src,
        output cin,
        output left,
        input res,
        input cout
    );
    modport unit
    (
        input src,
        input cin,
        input left,
        output res,
        output cout
    );
endinterface
`default_nettype wire
